/* File: hw/etcp_pkg.sv */
// Package for the enhanced timer with compare and PWM outputs.
// Holds register offsets, field positions, reset values and mode codes.
package etcp_pkg;
    localparam logic [2:0] ETCP_OFS_CTRL0 = 3'h0;
    localparam logic [2:0] ETCP_OFS_CHA_CTRL = 3'h1;
    localparam logic [2:0] ETCP_OFS_CHB_CTRL = 3'h2;
    localparam logic [2:0] ETCP_OFS_PERIOD = 3'h3;
    localparam logic [2:0] ETCP_OFS_CCA_LO = 3'h4;
    localparam logic [2:0] ETCP_OFS_CCA_HI = 3'h5;
    localparam logic [2:0] ETCP_OFS_CCB_LO = 3'h6;
    localparam logic [2:0] ETCP_OFS_CCB_HI = 3'h7;
    localparam int ETCP_ENABLE_BIT = 3;
    localparam int ETCP_FLAG_A_BIT = 0;
    localparam int ETCP_FLAG_B_BIT = 1;
    localparam int ETCP_FLAG_P_BIT = 2;
    localparam int ETCP_MODE_POS = 6;
    localparam int ETCP_FUNC_POS = 4;
    localparam int ETCP_INIT_BIT = 3;
    localparam int ETCP_INV_BIT = 2;
    localparam int ETCP_DIR_BIT = 1;
    localparam int ETCP_CLR_SEL_BIT = 0;
    localparam int ETCP_ALIGN_POS = 0;
    localparam logic [7:0] ETCP_CTRL_RST = 8'h00;
    localparam logic [7:0] ETCP_PERIOD_RST = 8'h00;
    localparam logic [15:0] ETCP_CC_RST = 16'h0000;
    localparam logic [1:0] ETCP_MODE_CMP = 2'h0;
    localparam logic [1:0] ETCP_MODE_CAP = 2'h1;
    localparam logic [1:0] ETCP_MODE_PWM = 2'h2;
    localparam logic [1:0] ETCP_MODE_TC = 2'h3;
    localparam logic [1:0] ETCP_FN_NONE = 2'h0;
    localparam logic [1:0] ETCP_FN_LOW = 2'h1;
    localparam logic [1:0] ETCP_FN_HIGH = 2'h2;
    localparam logic [1:0] ETCP_FN_TOGGLE = 2'h3;
    localparam logic [1:0] ETCP_CAP_OFF = 2'h3;
    localparam logic [1:0] ETCP_ALIGN_EDGE = 2'h0;
    localparam logic [1:0] ETCP_ALIGN_UP = 2'h1;
    localparam logic [1:0] ETCP_ALIGN_DOWN = 2'h2;
    localparam logic [1:0] ETCP_ALIGN_BOTH = 2'h3;
endpackage

/* File: hw/etcp_timer.sv */
// Dual channel enhanced timer: 16-bit counter, period and two compare values.
// Assumes a synchronous byte register port and synchronous pin inputs.
// Operation
// - Channel B capture edges; code 11 disables capture.
// - Output function zero leaves pin B unchanged.
// - Match to initial level shows no change.
// - Enable rising edge restores initial pin level.
// - Initial-level bit sets start or active level.
// - Invert bit inverts a driven pin; no effect in timer or capture mode.
// - Alignment field selects edge or centre matching.
// - Period compares with counter upper byte.
// - Period match clears counter; zero means overflow.
// - Clear-select low: period/overflow clear, A and P flags.
// - Clear-select high: A match clears, no P flag.
// - Pins change only on own channel match.
// - Timer mode as compare mode, pins undriven.
// - PWM clear-select high: A period, B duty.
// - PWM clear-select low: period steps of 256.
// - Edge aligned pulses start at counter zero.
// - PWM raises A and B flags; P only with clear-select low.
// - PWM function forces level or enables waveform.
// - Direction flag reads 0 up, 1 down.
// - Enable rise clears counter; fall freezes it.
// - Duty at or above period gives 100%.
`timescale 1ns/1ps
module etcp_timer
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Flag status and clearing, one bit per comparator A, B, P
    output logic [2:0] match_flags,
    input wire logic [2:0] match_flags_clr,
    // Channel pins
    input wire logic chan_a_pin_in,
    input wire logic chan_b_pin_in,
    output logic chan_a_pin,
    output logic chan_a_pin_oe,
    output logic chan_b_pin,
    output logic chan_b_pin_oe
);
    import etcp_pkg::*;

    logic [7:0] ctrl0_r;
    logic [7:0] chan_a_control_r;
    logic [7:0] channel_b_control_r;
    logic [7:0] period_compare_register_r;
    logic [15:0] chan_a_compare_value_r;
    logic [15:0] chan_b_compare_value_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic dir_down_r;
    logic dir_down_nxt;
    logic en_d_r;
    logic [2:0] flags_r;
    logic [2:0] flags_nxt;
    logic lvl_a_r;
    logic lvl_a_nxt;
    logic lvl_b_r;
    logic lvl_b_nxt;
    logic pin_b_in_d_r;
    logic [7:0] rdata_r;

    // Field decode.
    wire timer_enable_bit = ctrl0_r[ETCP_ENABLE_BIT];
    wire [1:0] mode_a = chan_a_control_r[ETCP_MODE_POS +: 2];
    wire [1:0] mode_b = channel_b_control_r[ETCP_MODE_POS +: 2];
    wire [1:0] func_a = chan_a_control_r[ETCP_FUNC_POS +: 2];
    wire [1:0] func_b = channel_b_control_r[ETCP_FUNC_POS +: 2];
    wire init_a = chan_a_control_r[ETCP_INIT_BIT];
    wire init_b = channel_b_control_r[ETCP_INIT_BIT];
    wire inv_a = chan_a_control_r[ETCP_INV_BIT];
    wire inv_b = channel_b_control_r[ETCP_INV_BIT];
    wire clr_sel = chan_a_control_r[ETCP_CLR_SEL_BIT];
    wire [1:0] align = channel_b_control_r[ETCP_ALIGN_POS +: 2];

    // Channel A mode governs the shared counter, as both must agree.
    wire is_cmp = (mode_a == ETCP_MODE_CMP);
    wire is_tc = (mode_a == ETCP_MODE_TC);
    wire is_pwm = (mode_a == ETCP_MODE_PWM);
    wire is_cap = (mode_a == ETCP_MODE_CAP);
    wire centre = is_pwm && (align != ETCP_ALIGN_EDGE);

    wire en_rise = timer_enable_bit && !en_d_r;
    wire run = timer_enable_bit;

    // Comparators.
    wire hit_a = run && (cnt_r == chan_a_compare_value_r);
    wire hit_b = run && (cnt_r == chan_b_compare_value_r);
    wire per_zero = (period_compare_register_r == 8'h00);
    wire hit_p = run && !per_zero && (cnt_r[15:8] == period_compare_register_r)
        && (cnt_r[7:0] == 8'h00);
    wire at_max = (cnt_r == 16'hFFFF);
    // An edge count clears on the step that would reach the match value, so the period
    // equals the programmed value instead of running one clock longer.
    wire [16:0] cnt_inc = {1'b0, cnt_r} + 17'h00001;
    wire reach_a = run && (cnt_inc == {1'b0, chan_a_compare_value_r});
    wire reach_p = run && !per_zero &&
        (cnt_inc == {1'b0, period_compare_register_r, 8'h00});
    wire a_match = (clr_sel && !centre) ? reach_a : hit_a;
    wire p_match = per_zero ? (run && at_max) : (centre ? hit_p : reach_p);
    // End of count: A match with clear-select high, else period or overflow.
    wire top = clr_sel ? a_match : p_match;
    // Period length for PWM duty comparison.
    wire [16:0] pwm_per = clr_sel ? {1'b0, chan_a_compare_value_r} :
        (per_zero ? 17'h10000 : {1'b0, period_compare_register_r, 8'h00});
    // Centre alignment may restrict on which direction matches count.
    wire dir_ok = !centre || (align == ETCP_ALIGN_BOTH) ||
        ((align == ETCP_ALIGN_UP) && !dir_down_r) ||
        ((align == ETCP_ALIGN_DOWN) && dir_down_r);
    wire ev_a = a_match && dir_ok;
    wire ev_b = hit_b && dir_ok;
    // Period flag suppressed when channel A clears the counter.
    wire ev_p = !clr_sel && p_match && !is_cap;

    // Counter: edge mode counts up and wraps; centre mode counts up then down.
    always_comb
    begin
        cnt_nxt = cnt_r;
        dir_down_nxt = dir_down_r;
        if (en_rise)
        begin
            cnt_nxt = 16'h0000;
            dir_down_nxt = 1'b0;
        end
        else if (run && !is_cap)
        begin
            if (centre)
            begin
                if (!dir_down_r && top)
                begin
                    dir_down_nxt = 1'b1;
                    cnt_nxt = cnt_r - 16'h0001;
                end
                else if (dir_down_r && (cnt_r == 16'h0000))
                begin
                    dir_down_nxt = 1'b0;
                    cnt_nxt = 16'h0001;
                end
                else if (dir_down_r)
                    cnt_nxt = cnt_r - 16'h0001;
                else
                    cnt_nxt = cnt_r + 16'h0001;
            end
            else if (top)
                cnt_nxt = 16'h0000;
            else
                cnt_nxt = cnt_r + 16'h0001;
        end
        else if (run)
            cnt_nxt = cnt_r + 16'h0001;
        // Disabled: counter holds its value.
    end

    // Sticky flags; a set in the clearing cycle wins.
    assign flags_nxt = (flags_r & ~match_flags_clr) |
        {ev_p && !is_cap, ev_b && !is_cap, ev_a && !is_cap};

    // Compare-mode level for one channel.
    function automatic logic cmp_level(input logic cur, input logic [1:0] fn);
        case (fn)
            ETCP_FN_LOW: cmp_level = 1'b0;
            ETCP_FN_HIGH: cmp_level = 1'b1;
            ETCP_FN_TOGGLE: cmp_level = !cur;
            default: cmp_level = cur;
        endcase
    endfunction

    // Pin levels move only on their own match; period never steers them.
    always_comb
    begin
        lvl_a_nxt = lvl_a_r;
        lvl_b_nxt = lvl_b_r;
        if (en_rise)
        begin
            lvl_a_nxt = init_a;
            lvl_b_nxt = init_b;
        end
        else
        begin
            if (ev_a)
                lvl_a_nxt = cmp_level(lvl_a_r, func_a);
            if (ev_b)
                lvl_b_nxt = cmp_level(lvl_b_r, func_b);
        end
    end

    // PWM active phase: counter below duty, or always when duty reaches period.
    wire act_a = ({1'b0, chan_a_compare_value_r} >= pwm_per) ||
        (cnt_r < chan_a_compare_value_r);
    wire act_b = ({1'b0, chan_b_compare_value_r} >= pwm_per) ||
        (cnt_r < chan_b_compare_value_r);

    function automatic logic pwm_level(input logic act, input logic fn_lo,
        input logic fn_hi, input logic pol);
        logic a;
        a = fn_hi ? act : fn_lo;
        pwm_level = pol ? a : !a;
    endfunction

    // Output composition: PWM levels, then inversion.
    wire raw_a = is_pwm ? pwm_level(act_a, func_a[0], func_a[1], init_a) : lvl_a_r;
    wire raw_b = is_pwm ? pwm_level(act_b, func_b[0], func_b[1], init_b) : lvl_b_r;
    wire drive_a = (is_cmp || is_pwm) && !(is_pwm && clr_sel);
    wire drive_b = is_cmp || is_pwm;

    // Capture on channel B edges, with code 11 meaning off.
    wire b_rise = chan_b_pin_in && !pin_b_in_d_r;
    wire b_fall = !chan_b_pin_in && pin_b_in_d_r;
    wire cap_b = is_cap && run && (func_b != ETCP_CAP_OFF) &&
        ((func_b == 2'h0) ? b_rise : (b_rise || b_fall));

    // Register read mux.
    wire [7:0] rd_mux =
        (reg_addr == ETCP_OFS_CTRL0) ? {ctrl0_r[7:3], flags_r} :
        (reg_addr == ETCP_OFS_CHA_CTRL) ?
            {chan_a_control_r[7:2], dir_down_r, chan_a_control_r[0]} :
        (reg_addr == ETCP_OFS_CHB_CTRL) ? channel_b_control_r :
        (reg_addr == ETCP_OFS_PERIOD) ? period_compare_register_r :
        (reg_addr == ETCP_OFS_CCA_LO) ? chan_a_compare_value_r[7:0] :
        (reg_addr == ETCP_OFS_CCA_HI) ? chan_a_compare_value_r[15:8] :
        (reg_addr == ETCP_OFS_CCB_LO) ? chan_b_compare_value_r[7:0] :
        chan_b_compare_value_r[15:8];

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl0_r <= ETCP_CTRL_RST;
            chan_a_control_r <= ETCP_CTRL_RST;
            channel_b_control_r <= ETCP_CTRL_RST;
            period_compare_register_r <= ETCP_PERIOD_RST;
            chan_a_compare_value_r <= ETCP_CC_RST;
            chan_b_compare_value_r <= ETCP_CC_RST;
        end
        else
        begin
            if (reg_wr && reg_addr == ETCP_OFS_CTRL0)
                ctrl0_r <= {reg_wdata[7:3], 3'h0};
            else if (reg_wr && reg_addr == ETCP_OFS_CHA_CTRL)
                chan_a_control_r <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
            else if (reg_wr && reg_addr == ETCP_OFS_CHB_CTRL)
                channel_b_control_r <= reg_wdata;
            else if (reg_wr && reg_addr == ETCP_OFS_PERIOD)
                period_compare_register_r <= reg_wdata;
            else if (reg_wr && reg_addr == ETCP_OFS_CCA_LO)
                chan_a_compare_value_r[7:0] <= reg_wdata;
            else if (reg_wr && reg_addr == ETCP_OFS_CCA_HI)
                chan_a_compare_value_r[15:8] <= reg_wdata;
            else if (reg_wr && reg_addr == ETCP_OFS_CCB_LO)
                chan_b_compare_value_r[7:0] <= reg_wdata;
            else if (reg_wr && reg_addr == ETCP_OFS_CCB_HI)
                chan_b_compare_value_r[15:8] <= reg_wdata;
            if (cap_b)
                chan_b_compare_value_r <= cnt_r;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cnt_r <= 16'h0000;
            dir_down_r <= 1'b0;
            en_d_r <= 1'b0;
            flags_r <= 3'h0;
            lvl_a_r <= 1'b0;
            lvl_b_r <= 1'b0;
            pin_b_in_d_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            dir_down_r <= dir_down_nxt;
            en_d_r <= timer_enable_bit;
            flags_r <= flags_nxt;
            lvl_a_r <= lvl_a_nxt;
            lvl_b_r <= lvl_b_nxt;
            pin_b_in_d_r <= chan_b_pin_in;
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Channel A input is reserved for the capture path beside this block.
    wire unused_a_in = chan_a_pin_in;

    assign reg_rdata = rdata_r;
    assign match_flags = flags_r;
    assign chan_a_pin = (raw_a ^ inv_a) && drive_a;
    assign chan_b_pin = (raw_b ^ inv_b) && drive_b;
    assign chan_a_pin_oe = drive_a;
    assign chan_b_pin_oe = drive_b;

    property p_flag_a_set;
        @(posedge mclk) disable iff (srst) (ev_a && !is_cap) |=> match_flags[ETCP_FLAG_A_BIT];
    endproperty
    a_flag_a_set: assert property (p_flag_a_set) else $error("flag A not set on match");

    property p_no_p_flag;
        @(posedge mclk) disable iff (srst)
            (clr_sel && !match_flags[ETCP_FLAG_P_BIT]) |=>
            !match_flags[ETCP_FLAG_P_BIT];
    endproperty
    a_no_p_flag: assert property (p_no_p_flag) else $error("period flag with clear select");

    property p_en_rise_clear;
        @(posedge mclk) disable iff (srst) en_rise |=> (cnt_r == 16'h0000);
    endproperty
    a_en_rise_clear: assert property (p_en_rise_clear) else $error("counter not cleared");

    property p_freeze;
        @(posedge mclk) disable iff (srst) (!timer_enable_bit ##1 !timer_enable_bit)
            |-> $stable(cnt_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved while off");

    property p_init_level;
        @(posedge mclk) disable iff (srst) (en_rise && is_cmp) |=> (lvl_b_r == $past(init_b));
    endproperty
    a_init_level: assert property (p_init_level) else $error("pin B not at initial level");

    property p_b_hold;
        @(posedge mclk) disable iff (srst) (!ev_b && !en_rise) |=> $stable(lvl_b_r);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("pin B moved without match");

    property p_tc_free;
        @(posedge mclk) disable iff (srst) is_tc |-> (!chan_a_pin_oe && !chan_b_pin_oe);
    endproperty
    a_tc_free: assert property (p_tc_free) else $error("pin driven in timer mode");

    property p_edge_wrap;
        @(posedge mclk) disable iff (srst)
            (run && !en_rise && !is_cap && !centre && !clr_sel && per_zero && at_max)
            |=> (cnt_r == 16'h0000);
    endproperty
    a_edge_wrap: assert property (p_edge_wrap) else $error("no overflow wrap");

    property p_full_duty;
        @(posedge mclk) disable iff (srst)
            (is_pwm && func_b == ETCP_FN_HIGH && init_b && !inv_b &&
            ({1'b0, chan_b_compare_value_r} >= pwm_per)) |-> chan_b_pin;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("duty not full");

    property p_p_flag_set;
        @(posedge mclk) disable iff (srst) ev_p |=> match_flags[ETCP_FLAG_P_BIT];
    endproperty
    a_p_flag_set: assert property (p_p_flag_set) else $error("period flag not set");

    property p_pwm_a_off;
        @(posedge mclk) disable iff (srst) (is_pwm && clr_sel) |-> !chan_a_pin_oe;
    endproperty
    a_pwm_a_off: assert property (p_pwm_a_off) else $error("pin A driven in PWM");

    property p_centre_turn;
        @(posedge mclk) disable iff (srst)
            (run && !en_rise && centre && !dir_down_r && top) |=> dir_down_r;
    endproperty
    a_centre_turn: assert property (p_centre_turn) else $error("no turn at top");

    property p_dir_read;
        @(posedge mclk) disable iff (srst) (reg_rd && reg_addr == ETCP_OFS_CHA_CTRL)
            |=> (reg_rdata[ETCP_DIR_BIT] == $past(dir_down_r));
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction flag misread");

    property p_edge_lead;
        @(posedge mclk) disable iff (srst)
            (is_pwm && !centre && func_b == ETCP_FN_HIGH && cnt_r == 16'h0000 &&
            chan_b_compare_value_r != 16'h0000) |-> (chan_b_pin == (init_b ^ inv_b));
    endproperty
    a_edge_lead: assert property (p_edge_lead) else $error("PWM edge not at count zero");
endmodule // etcp_timer

/* File: test/etcp_pin_load.sv */
// Load and signal source on one timer channel pin.
// Assumes the timer drives the pin only while its output enable is high.
`timescale 1ns/1ps
module etcp_pin_load
(
    // Timer side
    input wire logic pin,
    input wire logic oe,
    // Source side, used for capture edges
    input wire logic src_en,
    input wire logic src_lvl,
    // Resolved pin level
    output logic level
);
    // A released pin follows the source when src_en is high, else is pulled low, so the timer never sees a stale level.
    assign level = oe ? pin : (src_en ? src_lvl : 1'b0);
endmodule // etcp_pin_load

/* File: test/test_enhanced_timer_compare_pwm.sv */
// Self-checking bench for the timer: registers, compare, timer, PWM, capture.
// Assumes reads answer one cycle later and pins resolve in etcp_pin_load.
`timescale 1ns/1ps
module test_enhanced_timer_compare_pwm;
    import etcp_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] match_flags_clr = 3'h0;
    logic src_en = 1'b0;
    logic src_lvl = 1'b0;
    logic [7:0] reg_rdata, v;
    logic [2:0] match_flags;
    logic a_in, b_in, a_pin, a_oe, b_pin, b_oe, s0, s1;
    logic [4:0] t;
    logic [31:0] w;
    logic [4:0] cmp_tbl [8] = '{5'h00, 5'h18, 5'h06, 5'h1C, 5'h1A, 5'h04, 5'h19, 5'h12};
    logic [31:0] pwm_tbl [5] = '{32'hA80A0064, 32'hAC0A012C, 32'h880A0000, 32'h980A0190,
        32'hA8320190};
    int n_mismatch = 0;
    int n_checks = 0;
    int pa, pb, pp, ha, hb;

    always #4 mclk = ~mclk;

    etcp_timer uut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .match_flags(match_flags),
        .match_flags_clr(match_flags_clr), .chan_a_pin_in(a_in), .chan_b_pin_in(b_in),
        .chan_a_pin(a_pin), .chan_a_pin_oe(a_oe), .chan_b_pin(b_pin), .chan_b_pin_oe(b_oe));
    etcp_pin_load load_a (.pin(a_pin), .oe(a_oe), .src_en(1'b0), .src_lvl(1'b0), .level(a_in));
    etcp_pin_load load_b (.pin(b_pin), .oe(b_oe), .src_en(src_en), .src_lvl(src_lvl),
        .level(b_in));

    task close_out;
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    task rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
        rd(a, v);
        chk(nm, {8'h00, e}, {8'h00, v});
    endtask

    task wr16(input logic [2:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 3'h1, d[15:8]);
    endtask

    // The timer is stopped before any mode or function change, then restarted.
    task cfg(input logic [7:0] ca, input logic [7:0] cb);
        wr(ETCP_OFS_CTRL0, 8'h00);
        wr(ETCP_OFS_CHA_CTRL, ca);
        wr(ETCP_OFS_CHB_CTRL, cb);
        wr(ETCP_OFS_CTRL0, 8'h08);
        @(posedge mclk);
        match_flags_clr <= 3'h7;
        @(posedge mclk);
        match_flags_clr <= 3'h0;
        @(negedge mclk);
    endtask

    // Holding the clears makes each match one flag cycle, so pulses can be counted.
    task meas(input int n);
        pa = 0;
        pb = 0;
        pp = 0;
        ha = 0;
        hb = 0;
        @(posedge mclk);
        match_flags_clr <= 3'h7;
        repeat (2) @(posedge mclk);
        repeat (n)
        begin
            @(negedge mclk);
            pa += match_flags[0];
            pb += match_flags[1];
            pp += match_flags[2];
            ha += a_pin;
            hb += b_pin;
        end
        @(posedge mclk);
        match_flags_clr <= 3'h0;
    endtask

    task edges;
        repeat (4)
        begin
            repeat (10) @(posedge mclk);
            src_lvl <= ~src_lvl;
        end
    endtask

    initial
    begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        close_out;
    end

    initial
    begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rchk(3'(i), 8'h00, "reset_value");
        chk("oe_b_reset", 16'h0001, {15'h0, b_oe});
        wr(ETCP_OFS_CTRL0, 8'hF7);
        rchk(ETCP_OFS_CTRL0, 8'hF0, "ctrl0_flags_ro");
        wr(ETCP_OFS_CHA_CTRL, 8'hFF);
        rchk(ETCP_OFS_CHA_CTRL, 8'hFD, "dir_ro");
        wr(ETCP_OFS_CHB_CTRL, 8'hA5);
        rchk(ETCP_OFS_CHB_CTRL, 8'hA5, "chb_rw");
        wr(ETCP_OFS_PERIOD, 8'h5A);
        rchk(ETCP_OFS_PERIOD, 8'h5A, "period_rw");
        wr16(ETCP_OFS_CCA_LO, 16'h0028);
        wr16(ETCP_OFS_CCB_LO, 16'h0014);
        for (int i = 0; i < 8; i++)
        begin
            t = cmp_tbl[i];
            cfg(8'h01, {2'b00, t[3:0], 2'b00});
            chk("pin_initial", {15'h0, t[1] ^ t[0]}, {15'h0, b_pin});
            for (int k = 0; k < 60 && match_flags[1] !== 1'b1; k++)
                @(negedge mclk);
            chk("pin_matched", {15'h0, t[4] ^ t[0]}, {15'h0, b_pin});
        end
        meas(400);
        chk("a_clear_sel", 16'h000A, pa[15:0]);
        chk("p_clear_sel", 16'h0000, pp[15:0]);
        rchk(ETCP_OFS_CHA_CTRL, 8'h01, "dir_up");
        wr(ETCP_OFS_PERIOD, 8'h01);
        wr16(ETCP_OFS_CCB_LO, 16'h012C);
        cfg(8'h00, 8'h20);
        meas(512);
        chk("p_period", 16'h0002, pp[15:0]);
        chk("a_period", 16'h0002, pa[15:0]);
        chk("b_no_p_effect", 16'h0000, hb[15:0]);
        cfg(8'hC1, 8'hC0);
        chk("oe_timer", 16'h0000, {14'h0, a_oe, b_oe});
        meas(400);
        chk("a_timer", 16'h000A, pa[15:0]);
        for (int i = 0; i < 5; i++)
        begin
            w = pwm_tbl[i];
            wr16(ETCP_OFS_CCB_LO, {8'h00, w[23:16]});
            cfg(8'hA1, w[31:24]);
            chk("oe_a_pwm", 16'h0000, {15'h0, a_oe});
            meas(400);
            chk("b_high", w[15:0], hb[15:0]);
            chk("a_pwm", 16'h000A, pa[15:0]);
        end
        wr16(ETCP_OFS_CCA_LO, 16'h0040);
        wr16(ETCP_OFS_CCB_LO, 16'h0080);
        cfg(8'hA8, 8'hA8);
        meas(512);
        chk("a_high", 16'h0080, ha[15:0]);
        chk("b_high_p", 16'h0100, hb[15:0]);
        chk("p_pwm", 16'h0002, pp[15:0]);
        chk("b_pwm", 16'h0002, pb[15:0]);
        wr16(ETCP_OFS_CCA_LO, 16'h0028);
        wr16(ETCP_OFS_CCB_LO, 16'h000A);
        for (int k = 0; k < 4; k++)
        begin
            cfg(8'hA1, 8'hA8 | 8'(k));
            meas(480);
            chk("b_align", (k == 1 || k == 2) ? 16'h0006 : 16'h000C, pb[15:0]);
        end
        s0 = 1'b0;
        s1 = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            rd(ETCP_OFS_CHA_CTRL, v);
            s0 |= ~v[1];
            s1 |= v[1];
        end
        chk("dir_both", 16'h0003, {14'h0, s1, s0});
        wr(ETCP_OFS_CTRL0, 8'h00);
        repeat (30) @(posedge mclk);
        rd(ETCP_OFS_CTRL0, v);
        chk("flags_sticky", 16'h0003, {14'h0, v[1:0]});
        chk("flags_port", 16'h0003, {14'h0, match_flags[1:0]});
        cfg(8'h70, 8'h70);
        src_en <= 1'b1;
        edges;
        rchk(ETCP_OFS_CCB_LO, 8'h0A, "capture_off");
        cfg(8'h60, 8'h60);
        edges;
        rd(ETCP_OFS_CCB_LO, v);
        chk("capture_both", 16'h0001, {15'h0, v !== 8'h0A});
        close_out;
    end
endmodule // test_enhanced_timer_compare_pwm
